// ==== pkg/hpio_cfg.svh ====
`ifndef HPIO_CFG_SVH
`define HPIO_CFG_SVH

// Register byte offsets.
`define HPIO_OFF_CTRL     8'h00
`define HPIO_OFF_PORTA    8'h04
`define HPIO_OFF_PORTB    8'h08
`define HPIO_OFF_PORTCD   8'h0c
`define HPIO_OFF_VERDICT  8'h10
`define HPIO_OFF_SWEEP    8'h14
`define HPIO_OFF_LATCH    8'h18
`define HPIO_OFF_STATUS   8'h1c

// Control register field positions.
`define HPIO_CTRL_CDIR    0
`define HPIO_CTRL_DDIR    1
`define HPIO_CTRL_POL     2

// Reset values.
`define HPIO_RST_CTRL     3'h0
`define HPIO_RST_BYTE     8'h00
`define HPIO_RST_NIB      4'h0

// Timing: clock rate and least pulse widths.
`define HPIO_CLK_MHZ      200
`define HPIO_STROBE_NS    1000
`define HPIO_SWEEP_NS     10000
`define HPIO_STROBE_CYC   ((`HPIO_STROBE_NS * `HPIO_CLK_MHZ + 999) / 1000)
`define HPIO_SWEEP_CYC    ((`HPIO_SWEEP_NS * `HPIO_CLK_MHZ + 999) / 1000)

`endif

// ==== pkg/hpio_pkg.sv ====
package hpio_pkg;

   typedef enum logic [1:0] {
      HPIO_OKAY   = 2'b00,
      HPIO_SLVERR = 2'b10
   } hpio_resp_t;

   typedef enum logic [3:0] {
      HPIO_R_CTRL    = 4'b0000,
      HPIO_R_PORTA   = 4'b0001,
      HPIO_R_PORTB   = 4'b0010,
      HPIO_R_PORTCD  = 4'b0011,
      HPIO_R_VERDICT = 4'b0100,
      HPIO_R_SWEEP   = 4'b0101,
      HPIO_R_LATCH   = 4'b0110,
      HPIO_R_STATUS  = 4'b0111,
      HPIO_R_NONE    = 4'b1111
   } hpio_reg_t;

endpackage : hpio_pkg

// ==== rtl/hpio_pulse.sv ====
`timescale 1ns/1ps
module hpio_pulse #(
   parameter logic [11:0] WIDTH = 12'h0c8
) (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Trigger and pulse
   input  wire logic fire,
   output logic      pulse_n_q
);
   import hpio_pkg::*;

   logic [11:0] cnt_q;
   logic [11:0] low_q;

   // A fire while the pulse runs is dropped; the caller checks busy first.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pulse_n_q <= 1'b1;
         cnt_q     <= 12'h000;
      end else if (pulse_n_q && fire) begin
         pulse_n_q <= 1'b0;
         cnt_q     <= WIDTH - 12'h001;
      end else if (!pulse_n_q) begin
         if (cnt_q == 12'h000) begin
            pulse_n_q <= 1'b1;
         end else begin
            cnt_q <= cnt_q - 12'h001;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_q <= 12'h000;
      end else if (!pulse_n_q) begin
         low_q <= low_q + 12'h001;
      end else begin
         low_q <= 12'h000;
      end
   end

   pulse_width_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(pulse_n_q) |-> low_q == WIDTH)
      else $error("strobe pulse width differs from its configured count");

endmodule : hpio_pulse

// ==== rtl/hpio_top.sv ====
// Notes on behaviour
// - Two 8-bit output ports and two 4-bit bidirectional ports, TTL levels.
// - A low pulse on the trigger input latches the two single-bit outputs.
// - Each nibble port's direction line is low for input, high for output.
// - Every output port write gives an active-low strobe of at least 1 us.
// - Verdict line is latched and driven with configurable pass polarity.
// - Sweep completion gives an active-low pulse of at least 10 us.
// - Each verdict update gives its own active-low strobe of at least 1 us.
// - Direction and polarity change only through the remote register bus.
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "hpio_cfg.svh"
module hpio_top (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write channels
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output hpio_pkg::hpio_resp_t   s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read channels
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output hpio_pkg::hpio_resp_t   s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Handler latch trigger and latched pair
   input  wire logic              latch_trigger_input_n,
   output logic [1:0]             latched_output_pair,
   // Output byte ports and their strobe
   output logic [7:0]             first_byte_output,
   output logic [7:0]             second_byte_output,
   output logic                   port_wr_strobe_n,
   // Bidirectional nibble ports
   input  wire logic [3:0]        port_c_i,
   output logic [3:0]             port_c_o,
   output logic [3:0]             port_c_oe,
   output logic                   port_c_dir,
   input  wire logic [3:0]        port_d_i,
   output logic [3:0]             port_d_o,
   output logic [3:0]             port_d_oe,
   output logic                   port_d_dir,
   // Verdict and sweep
   output logic                   pass_fail,
   output logic                   pass_fail_strobe_n,
   output logic                   sweep_end_n
);
   import hpio_pkg::*;

   localparam logic [11:0] STROBE_CYC = 12'(`HPIO_STROBE_CYC);
   localparam logic [11:0] SWEEP_CYC  = 12'(`HPIO_SWEEP_CYC);

   function automatic hpio_reg_t hpio_decode(input logic [7:0] addr);
      if (addr == `HPIO_OFF_CTRL) return HPIO_R_CTRL;
      else if (addr == `HPIO_OFF_PORTA) return HPIO_R_PORTA;
      else if (addr == `HPIO_OFF_PORTB) return HPIO_R_PORTB;
      else if (addr == `HPIO_OFF_PORTCD) return HPIO_R_PORTCD;
      else if (addr == `HPIO_OFF_VERDICT) return HPIO_R_VERDICT;
      else if (addr == `HPIO_OFF_SWEEP) return HPIO_R_SWEEP;
      else if (addr == `HPIO_OFF_LATCH) return HPIO_R_LATCH;
      else if (addr == `HPIO_OFF_STATUS) return HPIO_R_STATUS;
      else return HPIO_R_NONE;
   endfunction : hpio_decode

   logic [7:0]  awaddr_q;
   logic        aw_got_q;
   logic [31:0] wdata_q;
   logic        wlane0_q;
   logic        w_got_q;
   logic [2:0]  ctrl_q;
   logic [1:0]  stage_q;
   logic        trig_prev_q;
   logic        verdict_q;
   logic        port_fire_q;
   logic        pf_fire_q;
   logic        sweep_fire_q;
   logic        do_write;
   hpio_reg_t   wsel;
   logic        port_busy;
   logic        pf_busy;
   logic        sweep_busy;
   logic        wr_err;
   logic        wr_ok;

   assign do_write   = aw_got_q && w_got_q && !s_axi_bvalid;
   assign wsel       = hpio_decode(awaddr_q);
   assign port_busy  = !port_wr_strobe_n || port_fire_q;
   assign pf_busy    = !pass_fail_strobe_n || pf_fire_q;
   assign sweep_busy = !sweep_end_n || sweep_fire_q;
   // Data under a running strobe must not move, so such writes are refused.
   assign wr_err = (wsel == HPIO_R_NONE) || (wsel == HPIO_R_STATUS)
      || (port_busy && (wsel == HPIO_R_PORTA || wsel == HPIO_R_PORTB
                        || wsel == HPIO_R_PORTCD))
      || (pf_busy && wsel == HPIO_R_VERDICT)
      || (sweep_busy && wsel == HPIO_R_SWEEP);
   assign wr_ok = do_write && !wr_err && wlane0_q;

   // Write address and data are taken in either order, one write at a time.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         aw_got_q      <= 1'b0;
         w_got_q       <= 1'b0;
         awaddr_q      <= 8'h00;
         wdata_q       <= 32'h0000_0000;
         wlane0_q      <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= HPIO_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q      <= s_axi_awaddr;
            aw_got_q      <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q      <= s_axi_wdata;
            wlane0_q     <= s_axi_wstrb[0];
            w_got_q      <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_err ? HPIO_SLVERR : HPIO_OKAY;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Configuration has no other writer than the bus.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q     <= `HPIO_RST_CTRL;
         port_c_dir <= 1'b0;
         port_d_dir <= 1'b0;
         port_c_oe  <= `HPIO_RST_NIB;
         port_d_oe  <= `HPIO_RST_NIB;
      end else if (wr_ok && wsel == HPIO_R_CTRL) begin
         ctrl_q     <= wdata_q[2:0];
         port_c_dir <= wdata_q[`HPIO_CTRL_CDIR];
         port_d_dir <= wdata_q[`HPIO_CTRL_DDIR];
         port_c_oe  <= {4{wdata_q[`HPIO_CTRL_CDIR]}};
         port_d_oe  <= {4{wdata_q[`HPIO_CTRL_DDIR]}};
      end
   end

   // Port data moves one cycle before its strobe falls.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         first_byte_output  <= `HPIO_RST_BYTE;
         second_byte_output <= `HPIO_RST_BYTE;
         port_c_o           <= `HPIO_RST_NIB;
         port_d_o           <= `HPIO_RST_NIB;
         port_fire_q        <= 1'b0;
      end else begin
         port_fire_q <= 1'b0;
         if (wr_ok && wsel == HPIO_R_PORTA) begin
            first_byte_output <= wdata_q[7:0];
            port_fire_q       <= 1'b1;
         end else if (wr_ok && wsel == HPIO_R_PORTB) begin
            second_byte_output <= wdata_q[7:0];
            port_fire_q        <= 1'b1;
         end else if (wr_ok && wsel == HPIO_R_PORTCD) begin
            port_c_o    <= wdata_q[3:0];
            port_d_o    <= wdata_q[7:4];
            port_fire_q <= 1'b1;
         end
      end
   end

   // The verdict is latched with the polarity in force when it is written.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         verdict_q <= 1'b0;
         pass_fail <= 1'b0;
         pf_fire_q <= 1'b0;
      end else begin
         pf_fire_q <= 1'b0;
         if (wr_ok && wsel == HPIO_R_VERDICT) begin
            verdict_q <= wdata_q[0];
            pass_fail <= wdata_q[0] ^ ctrl_q[`HPIO_CTRL_POL];
            pf_fire_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sweep_fire_q <= 1'b0;
      end else begin
         sweep_fire_q <= wr_ok && wsel == HPIO_R_SWEEP && wdata_q[0];
      end
   end

   // Capture on the falling edge; the handler keeps the pulse long enough.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stage_q             <= 2'h0;
         trig_prev_q         <= 1'b1;
         latched_output_pair <= 2'h0;
      end else begin
         trig_prev_q <= latch_trigger_input_n;
         if (wr_ok && wsel == HPIO_R_LATCH) begin
            stage_q <= wdata_q[1:0];
         end
         if (trig_prev_q && !latch_trigger_input_n) begin
            latched_output_pair <= stage_q;
         end
      end
   end

   hpio_pulse #(.WIDTH(STROBE_CYC)) u_port_strobe (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .fire      (port_fire_q),
      .pulse_n_q (port_wr_strobe_n)
   );

   hpio_pulse #(.WIDTH(STROBE_CYC)) u_pf_strobe (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .fire      (pf_fire_q),
      .pulse_n_q (pass_fail_strobe_n)
   );

   hpio_pulse #(.WIDTH(SWEEP_CYC)) u_sweep (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .fire      (sweep_fire_q),
      .pulse_n_q (sweep_end_n)
   );

   // One read at a time; the answer follows the address by one cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= HPIO_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= HPIO_OKAY;
         s_axi_rdata   <= 32'h0000_0000;
         case (hpio_decode(s_axi_araddr))
            HPIO_R_CTRL: begin
               s_axi_rdata[2:0] <= ctrl_q;
            end
            HPIO_R_PORTA: begin
               s_axi_rdata[7:0] <= first_byte_output;
            end
            HPIO_R_PORTB: begin
               s_axi_rdata[7:0] <= second_byte_output;
            end
            HPIO_R_PORTCD: begin
               s_axi_rdata[7:0] <= {port_d_o, port_c_o};
            end
            HPIO_R_VERDICT: begin
               s_axi_rdata[1:0] <= {pass_fail, verdict_q};
            end
            HPIO_R_SWEEP: begin
               s_axi_rdata[0] <= sweep_busy;
            end
            HPIO_R_LATCH: begin
               s_axi_rdata[3:0] <= {latched_output_pair, stage_q};
            end
            HPIO_R_STATUS: begin
               s_axi_rdata[11:0] <= {port_d_i, port_c_i, latch_trigger_input_n,
                                     sweep_busy, pf_busy, port_busy};
            end
            default: begin
               s_axi_rresp <= HPIO_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   dir_follows_oe_a: assert property (@(posedge aclk) disable iff (!aresetn)
      port_c_dir == port_c_oe[0] && port_d_dir == port_d_oe[3])
      else $error("direction line disagrees with nibble drive");

   nibble_oe_a: assert property (@(posedge aclk) disable iff (!aresetn)
      port_c_oe == {4{port_c_dir}} && port_d_oe == {4{port_d_dir}})
      else $error("nibble port enables are not uniform");

   sequence port_write_s;
      wr_ok && (wsel == HPIO_R_PORTA || wsel == HPIO_R_PORTB || wsel == HPIO_R_PORTCD);
   endsequence

   port_strobe_a: assert property (@(posedge aclk) disable iff (!aresetn)
      port_write_s |-> ##1 port_wr_strobe_n ##1 !port_wr_strobe_n [*8])
      else $error("output port strobe missing after a port write");

   port_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !port_wr_strobe_n |=> $stable({first_byte_output, second_byte_output,
                                     port_c_o, port_d_o}) || port_wr_strobe_n)
      else $error("port data moved during its strobe");

   sequence verdict_write_s;
      wr_ok && wsel == HPIO_R_VERDICT;
   endsequence

   // The new level shows one cycle ahead of the strobe and holds as it falls.
   sequence verdict_settled_s;
      pass_fail_strobe_n ##1 !pass_fail_strobe_n && $stable(pass_fail);
   endsequence

   verdict_strobe_a: assert property (@(posedge aclk) disable iff (!aresetn)
      verdict_write_s |=> verdict_settled_s)
      else $error("verdict strobe missing or verdict not settled");

   verdict_pol_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_ok && wsel == HPIO_R_VERDICT
         |=> pass_fail == ($past(wdata_q[0]) ^ $past(ctrl_q[`HPIO_CTRL_POL])))
      else $error("verdict polarity wrong");

   sweep_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
      sweep_fire_q |=> !sweep_end_n [*8])
      else $error("sweep end pulse missing");

   latch_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
      trig_prev_q && !latch_trigger_input_n |=> latched_output_pair == $past(stage_q))
      else $error("latched pair not captured on trigger");

   config_bus_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $changed(ctrl_q) |-> $past(wr_ok) && $past(wsel) == HPIO_R_CTRL)
      else $error("configuration changed without a bus write");

endmodule : hpio_top

// ==== bench/hpio_handler.sv ====
`timescale 1ns/1ps
module hpio_handler (
   // Clock
   input  wire logic       aclk,
   // Device side of the nibble ports
   input  wire logic [3:0] port_c_o,
   input  wire logic [3:0] port_c_oe,
   input  wire logic [3:0] port_d_o,
   input  wire logic [3:0] port_d_oe,
   // Handler drive
   output logic            latch_trigger_input_n,
   output logic [3:0]      port_c_i,
   output logic [3:0]      port_d_i
);
   logic [3:0] c_drv;
   logic [3:0] d_drv;

   initial begin
      latch_trigger_input_n = 1'b1;
      c_drv = 4'h0;
      d_drv = 4'h0;
   end

   // The handler lets go of every bit the device drives, so such a pin shows the device's level.
   assign port_c_i = (port_c_oe & port_c_o) | (~port_c_oe & c_drv);
   assign port_d_i = (port_d_oe & port_d_o) | (~port_d_oe & d_drv);

   task set_pins(input logic [3:0] c, input logic [3:0] d);
      @(posedge aclk);
      c_drv <= c;
      d_drv <= d;
   endtask : set_pins

   // Callers never ask for less than one microsecond of low level.
   task pulse(input int cycles);
      @(posedge aclk);
      latch_trigger_input_n <= 1'b0;
      repeat (cycles) @(posedge aclk);
      latch_trigger_input_n <= 1'b1;
   endtask : pulse
endmodule : hpio_handler

// ==== bench/hpio_top_tb.sv ====
`timescale 1ns/1ps
`include "hpio_cfg.svh"
module hpio_top_tb;
   import hpio_pkg::*;
   typedef struct packed {
      logic [7:0]  addr;
      logic [7:0]  data;
      logic [1:0]  resp;
      logic [1:0]  sel;
      logic [26:0] pins;
   } hpio_row_t;
   localparam logic [23:0] DAT = {8'ha5, 8'h3c, 4'h6, 4'h9};
   localparam hpio_row_t ROWS [12] = '{
      '{8'h00, 8'h03, 2'h0, 2'h0, {24'h0, 3'b110}},
      '{8'h04, 8'ha5, 2'h0, 2'h1, {8'ha5, 16'h0, 3'b110}},
      '{8'h08, 8'h3c, 2'h0, 2'h1, {16'ha53c, 8'h0, 3'b110}},
      '{8'h0c, 8'h96, 2'h0, 2'h1, {DAT, 3'b110}},
      '{8'h10, 8'h01, 2'h0, 2'h2, {DAT, 3'b111}},
      '{8'h00, 8'h05, 2'h0, 2'h0, {DAT, 3'b101}},
      '{8'h10, 8'h01, 2'h0, 2'h2, {DAT, 3'b100}},
      '{8'h10, 8'h00, 2'h0, 2'h2, {DAT, 3'b101}},
      '{8'h14, 8'h01, 2'h0, 2'h3, {DAT, 3'b101}},
      '{8'h1c, 8'h00, 2'h2, 2'h0, {DAT, 3'b101}},
      '{8'h20, 8'h00, 2'h2, 2'h0, {DAT, 3'b101}},
      '{8'h00, 8'h00, 2'h0, 2'h0, {DAT, 3'b001}}
   };
   logic        aclk, aresetn, latch_trigger_input_n, port_c_dir, port_d_dir;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, first_byte_output, second_byte_output;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdata;
   logic [3:0]  s_axi_wstrb, port_c_i, port_c_o, port_c_oe, port_d_i, port_d_o, port_d_oe;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, port_wr_strobe_n;
   logic        pass_fail, pass_fail_strobe_n, sweep_end_n;
   logic [1:0]  latched_output_pair;
   hpio_resp_t  s_axi_bresp, s_axi_rresp, resp;
   int          n_mismatch, samples_checked;

   hpio_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .latch_trigger_input_n, .latched_output_pair, .first_byte_output,
      .second_byte_output, .port_wr_strobe_n, .port_c_i, .port_c_o, .port_c_oe, .port_c_dir,
      .port_d_i, .port_d_o, .port_d_oe, .port_d_dir, .pass_fail, .pass_fail_strobe_n,
      .sweep_end_n);

   hpio_handler hdl (.aclk, .port_c_o, .port_c_oe, .port_d_o, .port_d_oe,
      .latch_trigger_input_n, .port_c_i, .port_d_i);

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   function logic [34:0] pins_now();
      return {first_byte_output, second_byte_output, port_c_o, port_d_o, port_c_dir,
              port_d_dir, pass_fail, port_c_oe, port_d_oe};
   endfunction : pins_now

   // Every enable bit of a nibble follows that port's direction line.
   function logic [34:0] exp_pins(input logic [26:0] p);
      return {p, {4{p[2]}}, {4{p[1]}}};
   endfunction : exp_pins

   function logic stb(input logic [1:0] sel);
      return (sel == 2'h1) ? port_wr_strobe_n : (sel == 2'h2) ? pass_fail_strobe_n : sweep_end_n;
   endfunction : stb

   task chk(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop

   task axi_wr(input logic [7:0] a, input logic [31:0] d, output hpio_resp_t r);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 100);
      if (s_axi_bvalid !== 1'b1) n_mismatch++;
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_wr

   task axi_rd(input logic [7:0] a, output logic [31:0] d, output hpio_resp_t r);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 100);
      if (s_axi_rvalid !== 1'b1) n_mismatch++;
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_rd

   // Pins are compared as the strobe falls and again as it rises, so any motion shows.
   task automatic strobe_chk(input logic [1:0] sel, input logic [26:0] p);
      int k;
      int n;
      k = 0;
      n = 0;
      #1;
      while (stb(sel) !== 1'b0 && k < 20) begin
         @(posedge aclk);
         #1;
         k++;
      end
      chk(pins_now(), exp_pins(p));
      while (stb(sel) === 1'b0 && n < 3000) begin
         @(posedge aclk);
         #1;
         n++;
      end
      chk(n, (sel == 2'h3) ? `HPIO_SWEEP_CYC : `HPIO_STROBE_CYC);
      chk(pins_now(), exp_pins(p));
   endtask : strobe_chk

   initial begin
      repeat (30000) @(posedge aclk);
      n_mismatch++;
      report_and_stop();
   end

   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'h1;
      aresetn = 1'b0;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      #1;
      chk({pins_now(), port_wr_strobe_n, pass_fail_strobe_n, sweep_end_n, latched_output_pair,
           s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid},
          {35'h0, 3'b111, 2'h0, 5'b11100});
      foreach (ROWS[i]) begin
         axi_wr(ROWS[i].addr, {24'h0, ROWS[i].data}, resp);
         chk(resp, ROWS[i].resp);
         if (ROWS[i].sel != 2'h0) begin
            strobe_chk(ROWS[i].sel, ROWS[i].pins);
         end else begin
            repeat (3) @(posedge aclk);
            #1;
            chk(pins_now(), exp_pins(ROWS[i].pins));
         end
      end
      // A second port write while the strobe still runs must leave the pins alone.
      axi_wr(`HPIO_OFF_PORTA, 32'h5a, resp);
      chk(resp, HPIO_OKAY);
      axi_wr(`HPIO_OFF_PORTB, 32'h00, resp);
      chk(resp, HPIO_SLVERR);
      repeat (`HPIO_STROBE_CYC + 8) @(posedge aclk);
      #1;
      chk({pins_now(), port_wr_strobe_n},
          {exp_pins({8'h5a, 8'h3c, 4'h6, 4'h9, 3'b001}), 1'b1});
      hdl.set_pins(4'h5, 4'ha);
      axi_wr(`HPIO_OFF_LATCH, 32'h2, resp);
      repeat (4) @(posedge aclk);
      #1;
      chk(latched_output_pair, 2'h0);
      hdl.pulse(`HPIO_STROBE_CYC);
      repeat (3) @(posedge aclk);
      #1;
      chk(latched_output_pair, 2'h2);
      axi_rd(`HPIO_OFF_STATUS, rdata, resp);
      chk({resp, rdata}, {HPIO_OKAY, 32'ha58});
      axi_rd(`HPIO_OFF_LATCH, rdata, resp);
      chk({resp, rdata}, {HPIO_OKAY, 32'ha});
      axi_rd(8'h20, rdata, resp);
      chk({resp, rdata}, {HPIO_SLVERR, 32'h0});
      // A write with lane zero off must leave the port and its strobe alone.
      s_axi_wstrb <= 4'h0;
      axi_wr(`HPIO_OFF_PORTA, 32'hff, resp);
      s_axi_wstrb <= 4'h1;
      chk(resp, HPIO_OKAY);
      repeat (4) @(posedge aclk);
      #1;
      chk({first_byte_output, port_wr_strobe_n}, {8'h5a, 1'b1});
      // Verdict and sweep writes are refused while their own pulse runs.
      axi_wr(`HPIO_OFF_VERDICT, 32'h1, resp);
      chk(resp, HPIO_OKAY);
      axi_wr(`HPIO_OFF_VERDICT, 32'h0, resp);
      chk(resp, HPIO_SLVERR);
      axi_rd(`HPIO_OFF_VERDICT, rdata, resp);
      chk({resp, rdata}, {HPIO_OKAY, 32'h3});
      axi_wr(`HPIO_OFF_SWEEP, 32'h1, resp);
      chk(resp, HPIO_OKAY);
      axi_wr(`HPIO_OFF_SWEEP, 32'h1, resp);
      chk(resp, HPIO_SLVERR);
      axi_rd(`HPIO_OFF_SWEEP, rdata, resp);
      chk({resp, rdata}, {HPIO_OKAY, 32'h1});
      // A polarity change alone must not move the verdict line.
      axi_wr(`HPIO_OFF_CTRL, 32'h6, resp);
      axi_rd(`HPIO_OFF_CTRL, rdata, resp);
      chk({resp, rdata, pass_fail}, {HPIO_OKAY, 32'h6, 1'b1});
      // A reset in mid-sweep brings every output back to idle.
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      #1;
      chk({pins_now(), port_wr_strobe_n, pass_fail_strobe_n, sweep_end_n, latched_output_pair,
           s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid},
          {35'h0, 3'b111, 2'h0, 5'b11100});
      axi_rd(`HPIO_OFF_CTRL, rdata, resp);
      chk({resp, rdata}, {HPIO_OKAY, 32'h0});
      report_and_stop();
   end
endmodule : hpio_top_tb
